// *** core/fpe_flash_seq.v ***
// Flash page erase-program sequencer with APB register access
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "fpe_regs.vh"

module fpe_flash_seq #(
  parameter [31:0] ERASE_CYCLES = `FPE_ERASE_CYCLES,
  parameter [31:0] PROG_CYCLES = `FPE_PROG_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire irq_pending,
  input wire brownout,
  input wire bod_enable,
  input wire hv_fault,
  input wire [15:0] sector_secure,
  output wire cpu_stall,
  output reg flash_erase_en,
  output reg flash_prog_en,
  output reg flash_chip_erase,
  output reg [9:0] flash_page,
  output reg [63:0] flash_byte_mask,
  output reg [511:0] flash_prog_data
);

  // ------------------------------------------------------------
  // Design notes
  // ------------------------------------------------------------
  // Register map
  //   0xE4 command on write, status on read
  //   0xE8 low address: [5:0] buffer slot, [7:6] page low bits
  //   0xEC high address: upper page bits
  //   0xF0 data byte into the page buffer
  //   0xF4 sequencer state, read only
  //   0xF8 busy flag and current buffer slot, read only
  //   Other offsets answer with an error and read as zero
  //   Writes to unmapped offsets are dropped
  //
  // Status bits
  //   [0] operation interrupted by a pending interrupt
  //   [1] security violation, no cycle was started
  //   [2] high voltage generator fault during a cycle
  //   [3] high voltage abort: interrupt, brown-out or detector off
  //   Every command write clears them first; a refusal sets its bit
  //   in the same edge, so the refusal always wins
  //
  // Commands
  //   00H clears the buffer and every update flag
  //   68H starts erase then program of the flagged bytes
  //   72H erases the whole array, no program phase
  //   Anything else only clears the status
  //
  // Cycle
  //   The bus answer is held off for the whole cycle, which is how
  //   the processor stall appears on this side of the bus
  //   Erase and program phases each run a fixed count of clocks,
  //   so the cycle length does not depend on how many bytes are set
  //   The mask and target page are latched at start; firmware
  //   writes during the cycle cannot reach the registers anyway
  //   An abort drops both phase enables in the next edge; the
  //   flash array sees a cut cycle and its content is undefined
  //   Interrupt, brown-out and fault inputs are levels, looked at
  //   on every edge of both phases
  //
  // Limitations
  //   A second write to one buffer slot overwrites it silently;
  //   the flag cannot tell firmware that this happened
  //   Bytes of other pages cannot be mixed into one cycle, since
  //   only one page address is latched
  //   After an abort the buffer keeps its bytes, but firmware is
  //   expected to clear and reload it before a retry
  //   Chip erase is refused while any sector is secured, which is
  //   cheaper than a per-sector skip in the erase control
  //   The 32-bit phase counter is wider than the default counts
  //   need; it keeps long phases possible at faster clocks
  //   The page buffer is plain flops, 64 bytes plus flags; a RAM
  //   would need a clear sequence of its own
  //
  // Interface timing
  //   Writes land on the access edge with select and enable high
  //   Reads are a plain mux, valid while a read is selected
  //   With the sequencer idle there are no wait states
  //   A transfer started during a cycle completes after it ends
  //
  // Reset
  //   All registers clear asynchronously; the bus is ready at once
  //   and no phase enable is driven until a start command
  //   A reset during a cycle ends it with no status bit set
  //

  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_ERASE = 2'd1;
  localparam ST_PROG = 2'd2;

  reg [1:0] state_q;
  reg [31:0] cnt_q;
  reg [3:0] status_q;
  reg [7:0] addr_low_q;
  reg [7:0] addr_high_q;
  reg [7:0] buf_q [0:63];
  reg [63:0] upd_q;
  reg chip_q;

  wire wr = psel & penable & pwrite;
  wire rd_sel = psel & ~pwrite;
  wire wr_cmd = wr & (paddr == `FPE_ADDR_CMD_STATUS);
  wire wr_data = wr & (paddr == `FPE_ADDR_WRITE_DATA);
  wire [7:0] cmd = pwdata[7:0];
  wire busy = (state_q != ST_IDLE);
  wire [9:0] page = {addr_high_q, addr_low_q[7:6]};
  // sector from page
  // Sector of the target page: 16 pages per 1 kB sector
  wire [3:0] sector = page[7:4];
  wire [31:0] cnt_inc = cnt_q + 32'h0000_0001;
  wire mapped = (paddr == `FPE_ADDR_CMD_STATUS) | (paddr == `FPE_ADDR_ADDR_LOW) |
                (paddr == `FPE_ADDR_ADDR_HIGH) | (paddr == `FPE_ADDR_WRITE_DATA) |
                (paddr == `FPE_ADDR_CTRL) | (paddr == `FPE_ADDR_PAGE_STAT);

  // Stalled CPU cannot issue bus cycles; APB answer waits for the cycle end
  assign pready = ~busy;
  assign pslverr = psel & penable & ~mapped;
  assign cpu_stall = busy;

  // ------------------------------------------------------------
  // Page buffer
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 64; gi = gi + 1) begin : g_buf
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          buf_q[gi] <= 8'h00;
          upd_q[gi] <= 1'b0;
        end else if (wr_cmd && !busy && cmd == `FPE_CMD_LOAD) begin
          buf_q[gi] <= 8'h00;
          upd_q[gi] <= 1'b0;
        end else if (wr_data && !busy && addr_low_q[5:0] == gi) begin
          buf_q[gi] <= pwdata[7:0];
          upd_q[gi] <= 1'b1;
        end
      end
      always @* begin
        flash_prog_data[gi*8 +: 8] = buf_q[gi];
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Address registers
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_low_q <= 8'h00;
      addr_high_q <= 8'h00;
    end else if (!busy) begin
      if (wr && paddr == `FPE_ADDR_ADDR_LOW) begin
        addr_low_q <= pwdata[7:0];
      end else if (wr && paddr == `FPE_ADDR_ADDR_HIGH) begin
        addr_high_q <= pwdata[7:0];
      end else if (wr_data) begin
        addr_low_q <= {addr_low_q[7:6], addr_low_q[5:0] + 6'h01};
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 32'h0000_0000;
      status_q <= `FPE_STATUS_RESET;
      chip_q <= 1'b0;
      flash_erase_en <= 1'b0;
      flash_prog_en <= 1'b0;
      flash_chip_erase <= 1'b0;
      flash_page <= 10'h000;
      flash_byte_mask <= 64'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (wr_cmd) begin
            status_q <= `FPE_STATUS_RESET;
            if (cmd == `FPE_CMD_ERASE_PROGRAM || cmd == `FPE_CMD_CHIP_ERASE) begin
              if (cmd == `FPE_CMD_ERASE_PROGRAM && sector_secure[sector]) begin
                status_q[`FPE_BIT_SV] <= 1'b1;
              end else if (cmd == `FPE_CMD_CHIP_ERASE && (|sector_secure)) begin
                status_q[`FPE_BIT_SV] <= 1'b1;
              end else if (!bod_enable) begin
                status_q[`FPE_BIT_HVA] <= 1'b1;
              end else begin
                state_q <= ST_ERASE;
                cnt_q <= 32'h0000_0000;
                chip_q <= (cmd == `FPE_CMD_CHIP_ERASE);
                flash_page <= page;
                flash_byte_mask <= (cmd == `FPE_CMD_CHIP_ERASE) ? {64{1'b1}} : upd_q;
                flash_chip_erase <= (cmd == `FPE_CMD_CHIP_ERASE);
                flash_erase_en <= 1'b1;
              end
            end
          end
        end
        ST_ERASE, ST_PROG: begin
          if (irq_pending || brownout || hv_fault) begin
            status_q[`FPE_BIT_OI] <= irq_pending;
            status_q[`FPE_BIT_HVA] <= irq_pending | brownout;
            status_q[`FPE_BIT_HVE] <= hv_fault;
            state_q <= ST_IDLE;
            flash_erase_en <= 1'b0;
            flash_prog_en <= 1'b0;
            flash_chip_erase <= 1'b0;
          end else if (cnt_inc >= (state_q == ST_ERASE ? ERASE_CYCLES : PROG_CYCLES)) begin
            cnt_q <= 32'h0000_0000;
            flash_erase_en <= 1'b0;
            flash_chip_erase <= 1'b0;
            if (state_q == ST_ERASE && !chip_q) begin
              state_q <= ST_PROG;
              flash_prog_en <= 1'b1;
            end else begin
              state_q <= ST_IDLE;
              flash_prog_en <= 1'b0;
            end
          end else begin
            cnt_q <= cnt_inc;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always @* begin
    prdata = 32'h0000_0000;
    if (rd_sel) begin
      case (paddr)
        `FPE_ADDR_CMD_STATUS: prdata = {28'h0, status_q};
        `FPE_ADDR_ADDR_LOW: prdata = {24'h0, addr_low_q};
        `FPE_ADDR_ADDR_HIGH: prdata = {24'h0, addr_high_q};
        `FPE_ADDR_CTRL: prdata = {30'h0, state_q};
        `FPE_ADDR_PAGE_STAT: prdata = {25'h0, busy, addr_low_q[5:0]};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule // fpe_flash_seq

// *** core/fpe_regs.vh ***
// Register map, field positions and timing constants of the flash page erase-program sequencer
`ifndef FPE_REGS_VH
`define FPE_REGS_VH
`define FPE_ADDR_CMD_STATUS 8'hE4
`define FPE_ADDR_ADDR_LOW 8'hE8
`define FPE_ADDR_ADDR_HIGH 8'hEC
`define FPE_ADDR_WRITE_DATA 8'hF0
`define FPE_ADDR_CTRL 8'hF4
`define FPE_ADDR_PAGE_STAT 8'hF8
`define FPE_CMD_LOAD 8'h00
`define FPE_CMD_ERASE_PROGRAM 8'h68
`define FPE_CMD_CHIP_ERASE 8'h72
`define FPE_BIT_OI 0
`define FPE_BIT_SV 1
`define FPE_BIT_HVE 2
`define FPE_BIT_HVA 3
`define FPE_STATUS_RESET 4'h0
`define FPE_PAGE_BYTES 64
`define FPE_SECTOR_BYTES 1024
`define FPE_CLK_MHZ 200
`define FPE_ERASE_US 2000
`define FPE_PROG_US 2000
`define FPE_ERASE_CYCLES (`FPE_ERASE_US * `FPE_CLK_MHZ)
`define FPE_PROG_CYCLES (`FPE_PROG_US * `FPE_CLK_MHZ)
`endif

// *** tb/fpe_flash_seq_assertions.sv ***
// Checker for the flash page erase-program sequencer ports
`timescale 1ns/1ps
`include "fpe_regs.vh"
module fpe_flash_seq_assertions #(
  parameter [31:0] ERASE_CYCLES = 20,
  parameter [31:0] PROG_CYCLES = 20
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire irq_pending,
  input wire brownout,
  input wire bod_enable,
  input wire hv_fault,
  input wire [15:0] sector_secure,
  input wire cpu_stall,
  input wire flash_erase_en,
  input wire flash_prog_en,
  input wire [9:0] flash_page,
  input wire [63:0] flash_byte_mask
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire go = psel && penable && pwrite && pready && paddr == `FPE_ADDR_CMD_STATUS && pwdata[7:0] == 8'h68;
  // An abort cuts a phase short, so its length is not checked then
  wire ab = irq_pending || brownout || hv_fault;
  reg [31:0] ecnt_q;
  reg [31:0] pcnt_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecnt_q <= 32'h0;
      pcnt_q <= 32'h0;
    end else begin
      ecnt_q <= flash_erase_en ? ecnt_q + 32'h1 : 32'h0;
      pcnt_q <= flash_prog_en ? pcnt_q + 32'h1 : 32'h0;
    end
  end
  a_stall_blocks_bus: assert property (cpu_stall |-> !pready) else $error("stall with bus ready");
  a_start_erases: assert property (go && !ab && bod_enable && sector_secure == 16'h0 |=> flash_erase_en && cpu_stall)
    else $error("cycle did not start");
  a_erase_len: assert property ($rose(flash_prog_en) |-> ecnt_q == ERASE_CYCLES) else $error("erase length");
  a_prog_len: assert property ($fell(flash_prog_en) && !$past(ab) |-> pcnt_q == PROG_CYCLES)
    else $error("program length");
  a_irq_aborts: assert property (cpu_stall && irq_pending |=> !cpu_stall) else $error("no abort");
  a_one_phase: assert property (!(flash_erase_en && flash_prog_en)) else $error("phases overlap");
  a_target_held: assert property (cpu_stall && $past(cpu_stall) |-> $stable(flash_page) && $stable(flash_byte_mask))
    else $error("target moved");
  a_secure_refused: assert property (go && sector_secure == 16'hFFFF |=> !cpu_stall) else $error("secured start");
  a_bod_refused: assert property (go && !bod_enable |=> !cpu_stall) else $error("start without detector");
  c_erase: cover property ($rose(flash_erase_en));
  c_prog_done: cover property ($fell(flash_prog_en));
  c_abort: cover property (cpu_stall && irq_pending);
endmodule // fpe_flash_seq_assertions
bind fpe_flash_seq fpe_flash_seq_assertions #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) i_chk (.*);

// *** tb/fpe_flash_seq_tb.sv ***
// Directed bench for the flash page erase-program sequencer
`timescale 1ns/1ps
`include "fpe_regs.vh"
module fpe_flash_seq_tb;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg irq_pending = 1'b0, brownout = 1'b0, hv_fault = 1'b0, bod_enable = 1'b1;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0, rdat;
  reg [15:0] sector_secure = 16'hFFFD;
  reg rerr;
  wire [31:0] prdata;
  wire pready, pslverr, cpu_stall, flash_erase_en, flash_prog_en, flash_chip_erase;
  wire [9:0] flash_page;
  wire [63:0] flash_byte_mask;
  wire [511:0] flash_prog_data;
  integer err_count = 0, n_checks = 0, cyc = 0;
  fpe_flash_seq #(.ERASE_CYCLES(20), .PROG_CYCLES(20)) i_fpe_flash_seq (.*);
  always #2.5 pclk = ~pclk;
  task finish_test;
    begin
      if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task cmp(input [511:0] g, input [511:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %0t got %0h", $time, g);
      end
    end
  endtask
  // ----------------------------------------
  // APB transfer, waits out a stalled access
  // ----------------------------------------
  task apb(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    apb(a, 1'b1, {24'h0, d});
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      apb(a, 1'b0, 32'h0);
      cmp(rdat, e);
    end
  endtask
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      finish_test;
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`FPE_ADDR_CMD_STATUS, 0);
    rd(8'hFC, 0);
    cmp(rerr, 1);
    wr(`FPE_ADDR_CMD_STATUS, 8'h00);
    wr(`FPE_ADDR_ADDR_LOW, 8'hBE);
    wr(`FPE_ADDR_WRITE_DATA, 8'h11);
    wr(`FPE_ADDR_WRITE_DATA, 8'h22);
    wr(`FPE_ADDR_WRITE_DATA, 8'h33);
    rd(`FPE_ADDR_ADDR_LOW, 32'h81);
    wr(`FPE_ADDR_ADDR_HIGH, 8'h05);
    wr(`FPE_ADDR_CMD_STATUS, 8'h68);
    @(negedge pclk);
    cmp(flash_erase_en & cpu_stall, 1);
    cmp(flash_page, 10'h016);
    cmp(flash_byte_mask, 64'hC000000000000001);
    cmp(flash_prog_data, {8'h22, 8'h11, 488'h0, 8'h33});
    rd(`FPE_ADDR_CMD_STATUS, 0);
    sector_secure <= 16'h0000;
    wr(`FPE_ADDR_CMD_STATUS, 8'h00);
    wr(`FPE_ADDR_CMD_STATUS, 8'h68);
    @(negedge pclk);
    cmp({flash_byte_mask, flash_prog_data}, 0);
    @(posedge pclk);
    irq_pending <= 1'b1;
    rd(`FPE_ADDR_CMD_STATUS, 32'h9);
    irq_pending <= 1'b0;
    wr(`FPE_ADDR_CMD_STATUS, 8'h01);
    rd(`FPE_ADDR_CMD_STATUS, 0);
    wr(`FPE_ADDR_CMD_STATUS, 8'h00);
    sector_secure <= 16'hFFFF;
    wr(`FPE_ADDR_CMD_STATUS, 8'h68);
    rd(`FPE_ADDR_CMD_STATUS, 32'h2);
    sector_secure <= 16'h0000;
    bod_enable <= 1'b0;
    wr(`FPE_ADDR_CMD_STATUS, 8'h68);
    rd(`FPE_ADDR_CMD_STATUS, 32'h8);
    bod_enable <= 1'b1;
    wr(`FPE_ADDR_CMD_STATUS, 8'h72);
    @(negedge pclk);
    cmp({flash_chip_erase, flash_byte_mask}, {1'b1, 64'hFFFFFFFFFFFFFFFF});
    rd(`FPE_ADDR_CMD_STATUS, 0);
    wr(`FPE_ADDR_CMD_STATUS, 8'h68);
    repeat (21) @(posedge pclk);
    cmp({flash_erase_en, flash_prog_en}, 2'b01);
    hv_fault <= 1'b1;
    rd(`FPE_ADDR_CMD_STATUS, 32'h4);
    hv_fault <= 1'b0;
    wr(`FPE_ADDR_CMD_STATUS, 8'h68);
    brownout <= 1'b1;
    rd(`FPE_ADDR_CMD_STATUS, 32'h8);
    brownout <= 1'b0;
    finish_test;
  end
endmodule // fpe_flash_seq_tb
